// ===== hdl/udch_host_ctrl.v
// host-side sequencer for a full-speed usb device controller: avalon
// registers in, command/data port of the device out
// assumes one clock; device pins are asynchronous and get synchronised
`timescale 1ns/1ps
`include "udch_defs.vh"

module udch_host_ctrl (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // avalon-mm slave
  input  wire [7:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [3:0]  avsByteEnable,
  input  wire [31:0] avsWriteData,
  output reg  [31:0] avsReadData,
  output reg         avsWaitRequest,
  // device command/data port
  output reg         devCsN,
  output reg         devRdN,
  output reg         devWrN,
  output reg         devA0,
  output reg  [15:0] devDataOut,
  output reg         devDataOeN,
  input  wire [15:0] devDataIn,
  input  wire        devIntN,
  input  wire        devSuspendIn
);
  localparam integer STROBE_NUM = `UDCH_STROBE_CYC;
  localparam integer RECOV_NUM  = `UDCH_RECOV_CYC;
  localparam [7:0]   STROBE_CYC = STROBE_NUM[7:0];
  localparam [7:0]   RECOV_CYC  = RECOV_NUM[7:0];
  localparam [2:0] S_IDLE = 3'h0, S_NEXT = 3'h1, S_SETUP = 3'h2, S_STROBE = 3'h3,
                   S_RECOV = 3'h4;
  localparam [1:0] M_GEN = 2'h0, M_CFG = 2'h1, M_ACK = 2'h2, M_SUS = 2'h3;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [15:0] dataMeta_ff, dataSync_ff;
  reg        intMeta_ff, intSync_ff, susMeta_ff, susSync_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dataMeta_ff <= 16'h0000;
      dataSync_ff <= 16'h0000;
      intMeta_ff  <= 1'b1;
      intSync_ff  <= 1'b1;
      susMeta_ff  <= 1'b0;
      susSync_ff  <= 1'b0;
    end else begin
      dataMeta_ff <= devDataIn;
      dataSync_ff <= dataMeta_ff;
      intMeta_ff  <= devIntN;
      intSync_ff  <= intMeta_ff;
      susMeta_ff  <= devSuspendIn;
      susSync_ff  <= susMeta_ff;
    end
  end

  // ----------------------------------------------------------------
  // endpoint configuration store and fifo budget
  // ----------------------------------------------------------------
  reg  [7:0]   ecfg_ff [0:15];
  wire [191:0] epPhys;
  wire [15:0]  epRes;
  wire [15:0]  epIso;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gEp
      wire [7:0]  c   = ecfg_ff[g];
      reg  [11:0] log;
      always @* begin
        case ({c[`UDCH_EC_ISO], c[3:0]})
          5'h00: log = 12'd8;
          5'h01: log = 12'd16;
          5'h02: log = 12'd32;
          5'h03: log = 12'd64;
          5'h10: log = 12'd16;
          5'h11: log = 12'd32;
          5'h12: log = 12'd48;
          5'h13: log = 12'd64;
          5'h14: log = 12'd96;
          5'h15: log = 12'd128;
          5'h16: log = 12'd160;
          5'h17: log = 12'd192;
          5'h18: log = 12'd256;
          5'h19: log = 12'd320;
          5'h1a: log = 12'd384;
          5'h1b: log = 12'd512;
          5'h1c: log = 12'd640;
          5'h1d: log = 12'd768;
          5'h1e: log = 12'd896;
          5'h1f: log = 12'd1023;
          default: log = 12'd0;
        endcase
      end
      // control pair is fixed at 64 bytes and always enabled
      if (g < 2) begin : gCtl
        assign epPhys[g*12 +: 12] = `UDCH_FIFO_CTRL;
        assign epRes[g] = 1'b0;
        assign epIso[g] = 1'b0;
      end else begin : gProg
        assign epPhys[g*12 +: 12] = !c[`UDCH_EC_EN] ? 12'd0 :
                                    c[`UDCH_EC_DBL] ? {log[10:0], 1'b0} : log;
        assign epRes[g] = c[`UDCH_EC_EN] & ~c[`UDCH_EC_ISO] & (c[3:2] != 2'h0);
        assign epIso[g] = c[`UDCH_EC_ISO];
      end
    end
  endgenerate

  reg [15:0] fifoTotal, nisoTotal;
  integer    i;
  always @* begin
    fifoTotal = 16'd0;
    nisoTotal = 16'd0;
    for (i = 0; i < 16; i = i + 1) begin
      fifoTotal = fifoTotal + {4'h0, epPhys[i*12 +: 12]};
      if (!epIso[i])
        nisoTotal = nisoTotal + {4'h0, epPhys[i*12 +: 12]};
    end
  end
  wire cfgBad = (|epRes) | (fifoTotal > `UDCH_FIFO_TOTAL) | (nisoTotal > `UDCH_FIFO_NISO);

  // ----------------------------------------------------------------
  // software registers and sequencer state
  // ----------------------------------------------------------------
  reg [7:0]  cmdCode_ff;
  reg [2:0]  cmdKind_ff;
  reg [15:0] wData_ff, rData_ff, hwCfg_ff;
  reg [7:0]  mode_ff;
  reg        enum_ff, cfgErr_ff, susAbort_ff, cfgRefused_ff, cfgDone_ff;
  reg [2:0]  state_ff;
  reg [1:0]  macro_ff;
  reg [4:0]  step_ff;
  reg        phase_ff;
  reg [7:0]  cnt_ff;

  wire       busy   = (state_ff != S_IDLE);
  wire       access = (avsRead | avsWrite) & ~avsWaitRequest;
  wire [7:0] regAdr = {avsAddress[7:2], 2'b00};
  wire       wrCtrl = access & avsWrite & (regAdr == `UDCH_REG_CTRL);
  wire [31:0] be    = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                       {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
  wire [31:0] wMask = avsWriteData & be;

  // step decode: what the current step sends to the device
  reg [7:0]  stepCode;
  reg [2:0]  stepKind;
  reg [15:0] stepData;
  reg        stepValid;
  always @* begin
    stepCode  = 8'h00;
    stepKind  = `UDCH_K_CMD;
    stepData  = 16'h0000;
    stepValid = 1'b0;
    case (macro_ff)
      M_GEN: begin
        stepValid = (step_ff == 5'd0);
        stepCode  = cmdCode_ff;
        stepKind  = cmdKind_ff;
        stepData  = wData_ff;
      end
      M_CFG: begin
        if (step_ff < 5'd16) begin
          stepValid = 1'b1;
          stepCode  = `UDCH_C_CFGWR + {4'h0, step_ff[3:0]};
          stepKind  = `UDCH_K_CMDWR;
          stepData  = {8'h00, ecfg_ff[step_ff[3:0]]};
        end else if (cfgErr_ff) begin
          stepValid = (step_ff == 5'd16);
          stepCode  = `UDCH_C_STALL + 8'h01;
        end else begin
          stepValid = (step_ff <= 5'd18);
          stepCode  = (step_ff == 5'd16) ? `UDCH_C_SEL + 8'h01 :
                      (step_ff == 5'd17) ? `UDCH_C_WRBUF : `UDCH_C_VALID;
          stepKind  = (step_ff == 5'd17) ? `UDCH_K_CMDWR : `UDCH_K_CMD;
        end
      end
      M_ACK: begin
        stepValid = (step_ff <= 5'd3);
        stepCode  = step_ff[0] ? `UDCH_C_ACKSET : `UDCH_C_SEL + {7'h00, step_ff[1]};
      end
      M_SUS: begin
        stepValid = (step_ff <= 5'd3);
        case (step_ff[1:0])
          2'h0: begin
            stepCode = `UDCH_C_INTRD;
            stepKind = `UDCH_K_CMDRD;
          end
          2'h1: begin
            stepCode = `UDCH_C_HWCFGWR;
            stepKind = `UDCH_K_CMDWR;
            stepData = hwCfg_ff & ~(16'h0001 << `UDCH_CLOCK_RUN_BIT_BIT);
          end
          default: begin
            stepCode = `UDCH_C_MODEWR;
            stepKind = `UDCH_K_CMDWR;
            stepData = {8'h00, step_ff[0] ? (mode_ff & ~(8'h01 << `UDCH_GO_SUSPEND_BIT_BIT))
                                          : (mode_ff | (8'h01 << `UDCH_GO_SUSPEND_BIT_BIT))};
          end
        endcase
      end
      default: stepValid = 1'b0;
    endcase
  end
  wire isRead  = (stepKind == `UDCH_K_CMDRD) | (stepKind == `UDCH_K_DATRD);
  wire hasData = (stepKind != `UDCH_K_CMD);

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avsWaitRequest <= 1'b1;
      avsReadData    <= 32'h0000_0000;
      cmdCode_ff     <= 8'h00;
      cmdKind_ff     <= 3'h0;
      wData_ff       <= 16'h0000;
      hwCfg_ff       <= 16'h0000;
      mode_ff        <= 8'h00;
      enum_ff        <= 1'b0;
    end else begin
      avsWaitRequest <= ~((avsRead | avsWrite) & avsWaitRequest);
      if ((avsRead | avsWrite) & avsWaitRequest) begin
        case (regAdr)
          `UDCH_REG_CTRL:   avsReadData <= {27'h0, enum_ff, 4'h0};
          `UDCH_REG_CMD:    avsReadData <= {21'h0, cmdKind_ff, cmdCode_ff};
          `UDCH_REG_WDATA:  avsReadData <= {16'h0, wData_ff};
          `UDCH_REG_RDATA:  avsReadData <= {16'h0, rData_ff};
          `UDCH_REG_STATUS: avsReadData <= {fifoTotal, 8'h00, enum_ff & cfgDone_ff,
                                            cfgDone_ff, susSync_ff, ~intSync_ff,
                                            cfgRefused_ff, susAbort_ff, cfgErr_ff, busy};
          `UDCH_REG_HWCFG:  avsReadData <= {16'h0, hwCfg_ff};
          `UDCH_REG_MODE:   avsReadData <= {24'h0, mode_ff};
          default: avsReadData <= (avsAddress[7:6] == `UDCH_REG_ECFG) ?
                                  {24'h0, ecfg_ff[avsAddress[5:2]]} : 32'h0000_0000;
        endcase
      end
      if (access & avsWrite) begin
        case (regAdr)
          `UDCH_REG_CTRL:  if (avsByteEnable[0]) enum_ff <= avsWriteData[`UDCH_CTRL_ENUM];
          `UDCH_REG_CMD:   {cmdKind_ff, cmdCode_ff} <= wMask[10:0] | ({cmdKind_ff, cmdCode_ff} & ~be[10:0]);
          `UDCH_REG_WDATA: wData_ff <= wMask[15:0] | (wData_ff & ~be[15:0]);
          `UDCH_REG_HWCFG: hwCfg_ff <= wMask[15:0] | (hwCfg_ff & ~be[15:0]);
          `UDCH_REG_MODE:  mode_ff <= wMask[7:0] | (mode_ff & ~be[7:0]);
          default: ;
        endcase
      end
    end
  end

  // config store; never written while the sequencer walks it
  integer    j;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (j = 0; j < 16; j = j + 1)
        ecfg_ff[j] <= 8'h00;
    end else if (access & avsWrite & (avsAddress[7:6] == `UDCH_REG_ECFG) & ~busy &
                 avsByteEnable[0]) begin
      ecfg_ff[avsAddress[5:2]] <= avsWriteData[7:0];
    end
  end

  // ----------------------------------------------------------------
  // device bus sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff      <= S_IDLE;
      macro_ff      <= M_GEN;
      step_ff       <= 5'd0;
      phase_ff      <= 1'b0;
      cnt_ff        <= 8'd0;
      rData_ff      <= 16'h0000;
      cfgErr_ff     <= 1'b0;
      susAbort_ff   <= 1'b0;
      cfgRefused_ff <= 1'b0;
      cfgDone_ff    <= 1'b0;
      devCsN        <= 1'b1;
      devRdN        <= 1'b1;
      devWrN        <= 1'b1;
      devA0         <= 1'b0;
      devDataOut    <= 16'h0000;
      devDataOeN    <= 1'b1;
    end else begin
      if (wrCtrl & avsByteEnable[1] & avsWriteData[`UDCH_CTRL_CLR]) begin
        susAbort_ff   <= 1'b0;
        cfgRefused_ff <= 1'b0;
      end
      case (state_ff)
        S_IDLE: begin
          step_ff <= 5'd0;
          if (wrCtrl & avsByteEnable[0]) begin
            if (avsWriteData[`UDCH_CTRL_CFG]) begin
              if (~intSync_ff)
                cfgRefused_ff <= 1'b1;
              else begin
                macro_ff   <= M_CFG;
                cfgErr_ff  <= cfgBad;
                cfgDone_ff <= 1'b0;
                state_ff   <= S_NEXT;
              end
            end else if (avsWriteData[`UDCH_CTRL_SUSP]) begin
              macro_ff <= M_SUS;
              state_ff <= S_NEXT;
            end else if (avsWriteData[`UDCH_CTRL_ACK]) begin
              macro_ff <= M_ACK;
              state_ff <= S_NEXT;
            end else if (avsWriteData[`UDCH_CTRL_GO]) begin
              macro_ff <= M_GEN;
              state_ff <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          if (!stepValid) begin
            if (macro_ff == M_CFG)
              cfgDone_ff <= 1'b1;
            state_ff <= S_IDLE;
          end else begin
            phase_ff <= (stepKind == `UDCH_K_DATWR) | (stepKind == `UDCH_K_DATRD);
            state_ff <= S_SETUP;
          end
        end
        S_SETUP: begin
          devCsN     <= 1'b0;
          devA0      <= ~phase_ff;
          devDataOut <= phase_ff ? stepData : {8'h00, stepCode};
          devDataOeN <= phase_ff & isRead;
          cnt_ff     <= STROBE_CYC;
          state_ff   <= S_STROBE;
        end
        S_STROBE: begin
          devRdN <= ~(phase_ff & isRead);
          devWrN <= phase_ff & isRead;
          cnt_ff <= cnt_ff - 8'd1;
          // sampled through the synchroniser, so strobe must cover two extra cycles
          if (cnt_ff == 8'd0) begin
            if (phase_ff & isRead)
              rData_ff <= dataSync_ff;
            devRdN   <= 1'b1;
            devWrN   <= 1'b1;
            cnt_ff   <= RECOV_CYC;
            state_ff <= S_RECOV;
          end
        end
        S_RECOV: begin
          devCsN     <= 1'b1;
          devDataOeN <= 1'b1;
          cnt_ff     <= cnt_ff - 8'd1;
          if (cnt_ff == 8'd1) begin
            if (!phase_ff & hasData) begin
              phase_ff <= 1'b1;
              state_ff <= S_SETUP;
            end else if (macro_ff == M_SUS && step_ff == 5'd0 &&
                         !rData_ff[`UDCH_BUSST_BIT]) begin
              susAbort_ff <= 1'b1;
              state_ff    <= S_IDLE;
            end else begin
              step_ff  <= step_ff + 5'd1;
              state_ff <= S_NEXT;
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // udch_host_ctrl

// ===== hdl/udch_defs.vh
// constants of the usb device-controller host sequencer
// included by udch_host_ctrl.v; definitions only
`ifndef UDCH_DEFS_VH
`define UDCH_DEFS_VH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define UDCH_CLK_MHZ      200
`define UDCH_STROBE_NS    60
`define UDCH_RECOV_NS     100
`define UDCH_STROBE_CYC   ((`UDCH_STROBE_NS * `UDCH_CLK_MHZ + 999) / 1000)
`define UDCH_RECOV_CYC    ((`UDCH_RECOV_NS * `UDCH_CLK_MHZ + 999) / 1000)
// ----------------------------------------------------------------
// avalon register byte addresses; ECFG is the value of address bits 7:6 for its window
// ----------------------------------------------------------------
`define UDCH_REG_CTRL     8'h00
`define UDCH_REG_CMD      8'h04
`define UDCH_REG_WDATA    8'h08
`define UDCH_REG_RDATA    8'h0c
`define UDCH_REG_STATUS   8'h10
`define UDCH_REG_HWCFG    8'h14
`define UDCH_REG_MODE     8'h18
`define UDCH_REG_ECFG     2'h1
// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define UDCH_CTRL_GO      0
`define UDCH_CTRL_CFG     1
`define UDCH_CTRL_ACK     2
`define UDCH_CTRL_SUSP    3
`define UDCH_CTRL_ENUM    4
`define UDCH_CTRL_CLR     8
// ----------------------------------------------------------------
// step kinds
// ----------------------------------------------------------------
`define UDCH_K_CMD        3'h0
`define UDCH_K_CMDWR      3'h1
`define UDCH_K_CMDRD      3'h2
`define UDCH_K_DATWR      3'h3
`define UDCH_K_DATRD      3'h4
// ----------------------------------------------------------------
// device command codes (arbitrary defaults)
// ----------------------------------------------------------------
`define UDCH_C_CFGWR      8'h20
`define UDCH_C_SEL        8'h00
`define UDCH_C_STALL      8'h40
`define UDCH_C_WRBUF      8'hf0
`define UDCH_C_VALID      8'hfa
`define UDCH_C_ACKSET     8'hf4
`define UDCH_C_INTRD      8'hc0
`define UDCH_C_HWCFGWR    8'hba
`define UDCH_C_MODEWR     8'hb8
// ----------------------------------------------------------------
// device field positions and endpoint config byte layout
// ----------------------------------------------------------------
`define UDCH_BUSST_BIT    8
`define UDCH_CLOCK_RUN_BIT_BIT   12
`define UDCH_GO_SUSPEND_BIT_BIT   5
`define UDCH_EC_EN        7
`define UDCH_EC_DBL       5
`define UDCH_EC_ISO       4
// ----------------------------------------------------------------
// fifo budget
// ----------------------------------------------------------------
`define UDCH_FIFO_TOTAL   16'd2462
`define UDCH_FIFO_NISO    16'd512
`define UDCH_FIFO_CTRL    12'd64
`endif

// ===== verification/udch_host_ctrl_chk.sv
// pin-level checks of the device host sequencer
// assumes one clock, reset active high; bound to every instance
`timescale 1ns/1ps
module udch_host_chk (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // avalon handshake
  input wire        avsRead,
  input wire        avsWrite,
  input wire        avsWaitRequest,
  // device port
  input wire        devCsN,
  input wire        devRdN,
  input wire        devWrN,
  input wire        devA0,
  input wire [15:0] devDataOut,
  input wire        devDataOeN
);
  reg [7:0] lowCnt_ff;
  reg [7:0] highCnt_ff;
  // -----------------------------------------------
  // strobe and recovery counters
  // -----------------------------------------------
  // high count saturates so idle stretches never wrap
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt_ff  <= 8'h00;
      highCnt_ff <= 8'hff;
    end else begin
      lowCnt_ff  <= (!devRdN || !devWrN) ? lowCnt_ff + 8'h01 : 8'h00;
      highCnt_ff <= !devCsN ? 8'h00 : (highCnt_ff == 8'hff ? 8'hff : highCnt_ff + 8'h01);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // -----------------------------------------------
  // properties
  // -----------------------------------------------
  a_wait_answer: assert property ($rose(avsRead || avsWrite) |=> !avsWaitRequest)
    else $error("waitrequest late after request");
  a_wait_pulse: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (!(avsRead || avsWrite) |=> avsWaitRequest)
    else $error("waitrequest low without request");
  a_strobe_excl: assert property (devRdN || devWrN)
    else $error("both strobes low");
  a_strobe_sel: assert property ((!devRdN || !devWrN) |-> !devCsN)
    else $error("strobe without chip select");
  a_wr_drive: assert property (!devWrN |-> !devDataOeN)
    else $error("write strobe with data undriven");
  a_rd_release: assert property (!devRdN |-> devDataOeN)
    else $error("read strobe while driving data");
  a_strobe_len: assert property (($rose(devRdN) || $rose(devWrN)) |-> lowCnt_ff == 8'd12)
    else $error("strobe width not 12 cycles");
  a_recov_gap: assert property ($fell(devCsN) |-> highCnt_ff >= 8'd20)
    else $error("recovery shorter than 20 cycles");
  a_setup_first: assert property ($fell(devCsN) |-> (devRdN && devWrN) ##1 !(devRdN && devWrN))
    else $error("setup cycle not followed by strobe");
  a_data_hold: assert property ((!devWrN && !$past(devWrN)) |-> $stable(devDataOut) && $stable(devA0))
    else $error("data moved during write strobe");
  c_write: cover property ($fell(devWrN));
  c_read: cover property ($fell(devRdN));
  c_bus: cover property (avsRead && !avsWaitRequest);
endmodule // udch_host_chk

bind udch_host_ctrl udch_host_chk u_udch_host_chk (.clk(clk), .rst(rst), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest), .devCsN(devCsN), .devRdN(devRdN),
  .devWrN(devWrN), .devA0(devA0), .devDataOut(devDataOut), .devDataOeN(devDataOeN));

// ===== verification/udch_dev_model.sv
// behavioural usb device controller on the command/data port
// assumes one word per strobe; bench drives the event inputs
`timescale 1ns/1ps
`include "udch_defs.vh"
module udch_dev_model (
  // controller pins
  input  wire        devCsN,
  input  wire        devRdN,
  input  wire        devWrN,
  input  wire        devA0,
  input  wire [15:0] devDataOut,
  input  wire        devDataOeN,
  output reg  [15:0] devDataIn,
  output wire        devIntN,
  output reg         devSuspendIn,
  // bench events
  input  wire        evtPend,
  input  wire        busIdle,
  input  wire        setupRx
);
  reg  [7:0]  endpoint_config_reg [0:15];
  reg  [7:0]  lastCmd;
  reg  [15:0] hwCfg;
  reg  [7:0]  mode;
  reg         lock;
  reg         armed;
  integer     i;
  wire [15:0] word = {7'h00, busIdle, 8'h00};
  assign devIntN = ~evtPend;
  initial begin
    for (i = 0; i < 16; i = i + 1)
      endpoint_config_reg[i] = 8'h00;
    lastCmd      = 8'h00;
    hwCfg        = 16'h0000;
    mode         = 8'h00;
    lock         = 1'b0;
    armed        = 1'b0;
    devSuspendIn = 1'b0;
  end
  // released bus shows the inverse so stale data never looks valid
  always @* begin
    if (!devDataOeN)
      devDataIn = devDataOut;
    else if (!devCsN && !devRdN)
      devDataIn = word;
    else
      devDataIn = ~word;
  end
  // bus activity wakes the device and drops its suspend output
  always @(negedge busIdle)
    devSuspendIn = 1'b0;
  always @(posedge setupRx) begin
    lock  = 1'b1;
    armed = 1'b0;
  end
  // captured at strobe start: select and data settle in setup
  always @(negedge devWrN) begin
    if (!devCsN && devA0) begin
      lastCmd = devDataOut[7:0];
      if (lastCmd == `UDCH_C_ACKSET)
        lock = 1'b0;
      if (lastCmd == `UDCH_C_VALID && !lock)
        armed = 1'b1;
    end else if (!devCsN) begin
      if (lastCmd[7:4] == 4'h2)
        endpoint_config_reg[lastCmd[3:0]] = devDataOut[7:0];
      if (lastCmd == `UDCH_C_HWCFGWR)
        hwCfg = devDataOut;
      if (lastCmd == `UDCH_C_MODEWR) begin
        if (mode[`UDCH_GO_SUSPEND_BIT_BIT] && !devDataOut[`UDCH_GO_SUSPEND_BIT_BIT])
          devSuspendIn = 1'b1;
        mode = devDataOut[7:0];
      end
    end
  end
endmodule // udch_dev_model

// ===== verification/udch_host_ctrl_test.sv
// self-checking bench of the device host sequencer
// assumes the device model and the bound checker are compiled first
`timescale 1ns/1ps
`include "udch_defs.vh"
`define CHK(got, exp) begin \
  nCompared = nCompared + 1; \
  if ((got) !== (exp)) begin \
    numErrors = numErrors + 1; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module udch_host_ctrl_test;
  localparam [159:0] ISO_TAB = {10'd1023, 10'd896, 10'd768, 10'd640, 10'd512, 10'd384,
    10'd320, 10'd256, 10'd192, 10'd160, 10'd128, 10'd96, 10'd64, 10'd48, 10'd32, 10'd16};
  reg         clk;
  reg         rst;
  reg  [7:0]  avsAddress;
  reg         avsRead;
  reg         avsWrite;
  reg  [31:0] avsWriteData;
  wire [31:0] avsReadData;
  wire        avsWaitRequest;
  wire        devCsN, devRdN, devWrN, devA0, devDataOeN, devIntN, devSuspendIn;
  wire [15:0] devDataOut, devDataIn;
  reg         evtPend, busIdle, setupRx;
  reg  [31:0] rd;
  reg  [7:0]  cfgTab [0:15];
  integer     numErrors, nCompared, cycles, i, c;
  udch_host_ctrl u_udch_host_ctrl (.clk(clk), .rst(rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsByteEnable(4'hf),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .devCsN(devCsN), .devRdN(devRdN), .devWrN(devWrN), .devA0(devA0),
    .devDataOut(devDataOut), .devDataOeN(devDataOeN), .devDataIn(devDataIn),
    .devIntN(devIntN), .devSuspendIn(devSuspendIn));
  udch_dev_model u_udch_dev_model (.devCsN(devCsN), .devRdN(devRdN), .devWrN(devWrN),
    .devA0(devA0), .devDataOut(devDataOut), .devDataOeN(devDataOeN), .devDataIn(devDataIn),
    .devIntN(devIntN), .devSuspendIn(devSuspendIn), .evtPend(evtPend), .busIdle(busIdle),
    .setupRx(setupRx));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task summarize;
    begin
      $display("compared %0d mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      numErrors = numErrors + 1;
      summarize;
    end
  end
  // entered just after an edge; leaves one idle cycle behind
  task acc(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      avsAddress   <= a;
      avsWriteData <= d;
      avsWrite     <= w;
      avsRead      <= !w;
      n = 0;
      @(posedge clk);
      while (avsWaitRequest !== 1'b0 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20)
        numErrors = numErrors + 1;
      rd = avsReadData;
      avsWrite <= 1'b0;
      avsRead  <= 1'b0;
      @(posedge clk);
    end
  endtask
  task waitIdle;
    integer k;
    begin
      k = 0;
      acc(1'b0, `UDCH_REG_STATUS, 32'h0);
      while (rd[0] !== 1'b0 && k < 2000) begin
        acc(1'b0, `UDCH_REG_STATUS, 32'h0);
        k = k + 1;
      end
      if (k == 2000)
        numErrors = numErrors + 1;
    end
  endtask
  task cfgClr;
    for (i = 0; i < 16; i = i + 1)
      cfgTab[i] = 8'h00;
  endtask
  task cfgRun(input [15:0] expTot, input expErr);
    begin
      for (i = 0; i < 16; i = i + 1)
        acc(1'b1, {2'b01, i[3:0], 2'b00}, {24'h0, cfgTab[i]});
      acc(1'b1, `UDCH_REG_CTRL, 32'h2);
      waitIdle;
      `CHK(rd[1], expErr);
      if (!expErr)
        `CHK(rd[31:16], expTot);
      `CHK(u_udch_dev_model.lastCmd, expErr ? 8'h41 : `UDCH_C_VALID);
    end
  endtask
  initial begin
    rst = 1'b1;
    avsAddress = 8'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0;
    evtPend = 1'b0;
    busIdle = 1'b1;
    setupRx = 1'b0;
    numErrors = 0;
    nCompared = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, `UDCH_REG_STATUS, 32'h0);
    `CHK(rd, {16'd128, 16'h0000});
    acc(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0);
    acc(1'b1, `UDCH_REG_HWCFG, 32'h0000ffff);
    acc(1'b1, 8'h48, 32'h000000a5);
    acc(1'b0, 8'h48, 32'h0);
    `CHK(rd[7:0], 8'ha5);
    acc(1'b0, `UDCH_REG_HWCFG, 32'h0);
    `CHK(rd[15:0], 16'hffff);
    $display("test registers done");
    cfgClr;
    cfgTab[2] = 8'hbf;
    cfgTab[3] = 8'h81;
    cfgTab[4] = 8'hc1;
    cfgTab[5] = 8'ha3;
    cfgTab[6] = 8'he3;
    cfgRun(16'd2462, 1'b0);
    for (i = 0; i < 16; i = i + 1)
      `CHK(u_udch_dev_model.endpoint_config_reg[i], cfgTab[i]);
    cfgTab[7] = 8'h90;
    cfgRun(16'd2478, 1'b1);
    cfgClr;
    for (i = 2; i < 5; i = i + 1)
      cfgTab[i] = 8'ha3;
    cfgRun(16'd512, 1'b0);
    cfgTab[5] = 8'ha3;
    cfgRun(16'd640, 1'b1);
    $display("test budget done");
    for (c = 0; c < 16; c = c + 1) begin
      cfgClr;
      cfgTab[2] = 8'h90 | c[7:0];
      cfgRun(16'd128 + {6'h00, ISO_TAB[c*10 +: 10]}, 1'b0);
    end
    for (c = 0; c < 5; c = c + 1) begin
      cfgTab[2] = 8'h80 | c[7:0];
      cfgRun(16'd128 + (16'd8 << c), c > 3);
    end
    $display("test size codes done");
    evtPend <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b1, `UDCH_REG_CTRL, 32'h2);
    acc(1'b0, `UDCH_REG_STATUS, 32'h0);
    `CHK({rd[4:3], rd[0]}, 3'b110);
    evtPend <= 1'b0;
    acc(1'b1, `UDCH_REG_CTRL, 32'h100);
    acc(1'b0, `UDCH_REG_STATUS, 32'h0);
    `CHK(rd[4:3], 2'b00);
    $display("test refusal done");
    setupRx <= 1'b1;
    @(posedge clk);
    setupRx <= 1'b0;
    cfgClr;
    cfgRun(16'd128, 1'b0);
    `CHK(u_udch_dev_model.armed, 1'b0);
    acc(1'b1, `UDCH_REG_CTRL, 32'h4);
    waitIdle;
    `CHK(u_udch_dev_model.lock, 1'b0);
    cfgRun(16'd128, 1'b0);
    `CHK(u_udch_dev_model.armed, 1'b1);
    $display("test setup lock done");
    busIdle <= 1'b0;
    acc(1'b1, `UDCH_REG_CTRL, 32'h8);
    waitIdle;
    `CHK({rd[5], rd[2]}, 2'b01);
    busIdle <= 1'b1;
    acc(1'b1, `UDCH_REG_CTRL, 32'h8);
    waitIdle;
    `CHK(rd[5], 1'b1);
    `CHK(u_udch_dev_model.hwCfg, 16'hefff);
    acc(1'b0, `UDCH_REG_RDATA, 32'h0);
    `CHK(rd[15:0], 16'h0100);
    busIdle <= 1'b0;
    repeat (4) @(posedge clk);
    acc(1'b0, `UDCH_REG_STATUS, 32'h0);
    `CHK(rd[5], 1'b0);
    $display("test suspend done");
    summarize;
  end
endmodule // udch_host_ctrl_test
